// ---- include/wku_regs.svh ----
`ifndef WKU_REGS_SVH
`define WKU_REGS_SVH
// byte addresses on the register bus
`define WKU_EDGE1_OFS 8'h00
`define WKU_EDGE2_OFS 8'h04
`define WKU_EDGE3_OFS 8'h08
`define WKU_PEND1_OFS 8'h0c
`define WKU_PEND2_OFS 8'h10
`define WKU_PEND3_OFS 8'h14
`define WKU_EN1_OFS 8'h18
`define WKU_EN2_OFS 8'h1c
`define WKU_EN3_OFS 8'h20
`define WKU_PCL1_OFS 8'h24
`define WKU_PCL2_OFS 8'h28
`define WKU_PCL3_OFS 8'h2c
`define WKU_STAT_OFS 8'h30
`define WKU_MASK_OFS 8'h34
`define WKU_CTL_OFS 8'h38
// reset values
`define WKU_EDGE_RST 24'h000000
`define WKU_PEND_RST 24'h000000
`define WKU_EN_RST 24'h000000
`define WKU_EV_RST 2'h0
// status / mask bits
`define WKU_EV_WAKE 0
`define WKU_EV_REFUSE 1
// control bits
`define WKU_CTL_IDLE 0
// wake input numbering inside the 24-bit vectors
`define WKU_IN20 8
`define WKU_IN24 12
`define WKU_IN26 14
`define WKU_IN27 15
`endif

// ---- include/wku_pkg.sv ----
`default_nettype none
package wku_pkg;
   typedef enum logic [0:0] {BusIdle, BusDone} wku_bus_st_t;
   typedef enum logic [2:0] {
      RegEdge, RegPend, RegEn, RegClr, RegStat, RegMask, RegCtl, RegNone
   } wku_reg_t;
   typedef struct packed {
      wku_reg_t kind;
      logic [1:0] grp;
   } wku_dec_t;
endpackage
`default_nettype wire

// ---- include/wku_edge_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface wku_edge_if;
   logic [23:0] rawIn;
   logic [23:0] edgeSel;
   logic [23:0] hit;
   modport det (input rawIn, input edgeSel, output hit);
   modport ctl (output rawIn, output edgeSel, input hit);
endinterface
`default_nettype wire

// ---- rtl/wku_rst_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module wku_rst_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rstSync_n
);
   logic stage1_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_q <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         stage1_q <= 1'b1;
         rstSync_n <= stage1_q;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/wku_edge_det.sv ----
`timescale 1ns/10ps
`default_nettype none
module wku_edge_det (
   input wire logic clk,
   input wire logic rstSync_n,
   wku_edge_if.det edge_p
);
   logic [23:0] prev_q;
   logic [23:0] prev_d;
   always_comb begin
      prev_d = edge_p.rawIn;
   end
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         prev_q <= 24'h000000;
      end else begin
         prev_q <= prev_d;
      end
   end
   // one-cycle hit on the selected edge: 0 rising, 1 falling
   for (genvar i = 0; i < 24; i++) begin : g_bit
      assign edge_p.hit[i] = edge_p.edgeSel[i] ?
         (prev_q[i] & ~edge_p.rawIn[i]) :
         (~prev_q[i] & edge_p.rawIn[i]);
   end
endmodule
`default_nettype wire

// ---- rtl/wku_wake_unit.sv ----
// Behaviour
// - 24 inputs in three byte-wide groups
// - selected edge sets sticky pending bit
// - select 0 rising edge, 1 falling edge
// - edge selects reset to zero
// - detection runs independent of bus or idle
// - idle refused while enabled input pending
// - wake request is OR of pending-and-enabled
// - only enabled inputs can end idle
// - outputs 20-25 and 27 go to interrupts
// - disabled input drives its output raw
// - enabled input drives its pending bit
// - group one and three interrupt lines
// - group one line ORed with output 24
// - pending bits reset to zero
// - pending write of one sets, zero keeps
// - clear register write one clears pending
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "wku_regs.svh"
module wku_wake_unit
   import wku_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [23:0] wakeInput,
   output logic wakeRequest,
   output logic idleGrant,
   output logic [6:0] individualWakeOut,
   output logic groupOneInterrupt,
   output logic groupThreeInterrupt,
   output logic combinedWakeInterrupt,
   output logic irq
);
   logic rstSync_n;
   wku_edge_if edgeBus ();

   wku_rst_sync i_wku_rst_sync (
      .clk(clk),
      .rst_n(rst_n),
      .rstSync_n(rstSync_n)
   );

   wku_edge_det i_wku_edge_det (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .edge_p(edgeBus)
   );

   function automatic wku_dec_t decode(input logic [7:0] a);
      wku_dec_t d;
      d.kind = RegNone;
      d.grp = 2'h0;
      case (a)
         `WKU_EDGE1_OFS: d = '{RegEdge, 2'h0};
         `WKU_EDGE2_OFS: d = '{RegEdge, 2'h1};
         `WKU_EDGE3_OFS: d = '{RegEdge, 2'h2};
         `WKU_PEND1_OFS: d = '{RegPend, 2'h0};
         `WKU_PEND2_OFS: d = '{RegPend, 2'h1};
         `WKU_PEND3_OFS: d = '{RegPend, 2'h2};
         `WKU_EN1_OFS: d = '{RegEn, 2'h0};
         `WKU_EN2_OFS: d = '{RegEn, 2'h1};
         `WKU_EN3_OFS: d = '{RegEn, 2'h2};
         `WKU_PCL1_OFS: d = '{RegClr, 2'h0};
         `WKU_PCL2_OFS: d = '{RegClr, 2'h1};
         `WKU_PCL3_OFS: d = '{RegClr, 2'h2};
         `WKU_STAT_OFS: d = '{RegStat, 2'h0};
         `WKU_MASK_OFS: d = '{RegMask, 2'h0};
         `WKU_CTL_OFS: d = '{RegCtl, 2'h0};
         default: d = '{RegNone, 2'h0};
      endcase
      return d;
   endfunction

   function automatic logic [4:0] grpBase(input logic [1:0] g);
      return {g, 3'h0};
   endfunction

   wku_bus_st_t busSt_q, busSt_d;
   logic pready_q, pready_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic [23:0] edgeSel_q, edgeSel_d;
   logic [23:0] en_q, en_d;
   logic [23:0] pend_q, pend_d;
   logic [1:0] stat_q, stat_d;
   logic [1:0] mask_q, mask_d;
   logic idleReq_q, idleReq_d;
   logic idleGrant_q, idleGrant_d;
   logic wakeReq_q, wakeReq_d;
   logic [6:0] indiv_q, indiv_d;
   logic grpOne_q, grpOne_d;
   logic grpThree_q, grpThree_d;
   logic comb_q, comb_d;
   logic irq_q, irq_d;

   wku_dec_t dec;
   logic wrAcc;
   logic [23:0] setMask;
   logic [23:0] clrMask;
   logic [23:0] active;
   logic [23:0] indivAll;
   logic [1:0] ev;

   assign edgeBus.rawIn = wakeInput;
   assign edgeBus.edgeSel = edgeSel_q;
   assign dec = decode(paddr);
   // a write takes effect at the edge where pready is sampled high
   assign wrAcc = psel & penable & pwrite & pready_q;

   // bus handshake: one wait state, then pready for one cycle
   always_comb begin
      busSt_d = busSt_q;
      pready_d = 1'b0;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      case (busSt_q)
         BusIdle: begin
            if (psel && penable) begin
               busSt_d = BusDone;
               pready_d = 1'b1;
               pslverr_d = (dec.kind == RegNone);
               prdata_d = 32'h00000000;
               if (!pwrite) begin
                  case (dec.kind)
                     RegEdge:
                        prdata_d[7:0] = edgeSel_q[grpBase(dec.grp) +: 8];
                     RegPend:
                        prdata_d[7:0] = pend_q[grpBase(dec.grp) +: 8];
                     RegEn:
                        prdata_d[7:0] = en_q[grpBase(dec.grp) +: 8];
                     RegStat: prdata_d[1:0] = stat_q;
                     RegMask: prdata_d[1:0] = mask_q;
                     RegCtl: prdata_d[`WKU_CTL_IDLE] = idleReq_q;
                     default: prdata_d = 32'h00000000;
                  endcase
               end
            end
         end
         BusDone: busSt_d = BusIdle;
         default: busSt_d = BusIdle;
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         busSt_q <= BusIdle;
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         busSt_q <= busSt_d;
         pready_q <= pready_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // software set and clear masks for the pending bits
   always_comb begin
      setMask = 24'h000000;
      clrMask = 24'h000000;
      if (wrAcc && dec.kind == RegPend) begin
         setMask[grpBase(dec.grp) +: 8] = pwdata[7:0];
      end
      if (wrAcc && dec.kind == RegClr) begin
         clrMask[grpBase(dec.grp) +: 8] = pwdata[7:0];
      end
   end

   // configuration and pending state
   always_comb begin
      edgeSel_d = edgeSel_q;
      en_d = en_q;
      mask_d = mask_q;
      idleReq_d = idleReq_q;
      if (wrAcc) begin
         case (dec.kind)
            RegEdge: edgeSel_d[grpBase(dec.grp) +: 8] = pwdata[7:0];
            RegEn: en_d[grpBase(dec.grp) +: 8] = pwdata[7:0];
            RegMask: mask_d = pwdata[1:0];
            RegCtl: idleReq_d = pwdata[`WKU_CTL_IDLE];
            default: mask_d = mask_q;
         endcase
      end
      // edge hits and software sets win over a clear in the same cycle
      pend_d = (pend_q & ~clrMask) | edgeBus.hit | setMask;
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         edgeSel_q <= `WKU_EDGE_RST;
         en_q <= `WKU_EN_RST;
         pend_q <= `WKU_PEND_RST;
         mask_q <= `WKU_EV_RST;
         idleReq_q <= 1'b0;
      end else begin
         edgeSel_q <= edgeSel_d;
         en_q <= en_d;
         pend_q <= pend_d;
         mask_q <= mask_d;
         idleReq_q <= idleReq_d;
      end
   end

   assign active = pend_q & en_q;
   // enabled inputs show pending, disabled ones pass the raw input
   assign indivAll = (en_q & pend_q) | (~en_q & wakeInput);

   // outputs toward power control and the interrupt unit
   always_comb begin
      wakeReq_d = |active;
      idleGrant_d = idleReq_q & ~(|active);
      indiv_d = {indivAll[`WKU_IN27], indivAll[`WKU_IN20 +: 6]};
      grpOne_d = |active[7:0];
      grpThree_d = |active[23:16];
      comb_d = (|active[7:0]) | indivAll[`WKU_IN24];
      ev = 2'h0;
      ev[`WKU_EV_WAKE] = (|active) & ~wakeReq_q;
      ev[`WKU_EV_REFUSE] = idleReq_q & (|active);
      stat_d = stat_q;
      if (wrAcc && dec.kind == RegStat) begin
         stat_d = stat_q & ~pwdata[1:0];
      end
      stat_d = stat_d | ev;
      irq_d = |(stat_q & mask_q);
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         wakeReq_q <= 1'b0;
         idleGrant_q <= 1'b0;
         indiv_q <= 7'h00;
         grpOne_q <= 1'b0;
         grpThree_q <= 1'b0;
         comb_q <= 1'b0;
         stat_q <= `WKU_EV_RST;
         irq_q <= 1'b0;
      end else begin
         wakeReq_q <= wakeReq_d;
         idleGrant_q <= idleGrant_d;
         indiv_q <= indiv_d;
         grpOne_q <= grpOne_d;
         grpThree_q <= grpThree_d;
         comb_q <= comb_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign wakeRequest = wakeReq_q;
   assign idleGrant = idleGrant_q;
   assign individualWakeOut = indiv_q;
   assign groupOneInterrupt = grpOne_q;
   assign groupThreeInterrupt = grpThree_q;
   assign combinedWakeInterrupt = comb_q;
   assign irq = irq_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstSync_n);

   property p_pend_set;
      (|edgeBus.hit) |=> ((pend_q & $past(edgeBus.hit)) == $past(edgeBus.hit));
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("edge hit did not set pending");

   property p_pend_hold;
      1'b1 |=> ((($past(pend_q) & ~pend_q) & ~$past(clrMask)) == 24'h0);
   endproperty
   a_pend_hold: assert property (p_pend_hold)
      else $error("pending bit cleared without clear write");

   property p_rise_sel;
      ($rose(wakeInput[0]) && !edgeSel_q[0]) |-> ##1 pend_q[0];
   endproperty
   a_rise_sel: assert property (p_rise_sel)
      else $error("rising edge missed with select zero");

   property p_fall_sel;
      ($fell(wakeInput[`WKU_IN26]) && edgeSel_q[`WKU_IN26]) |->
         ##1 pend_q[`WKU_IN26];
   endproperty
   a_fall_sel: assert property (p_fall_sel)
      else $error("falling edge missed with select one");

   property p_clr;
      (wrAcc && dec.kind == RegClr && dec.grp == 2'h0 && pwdata[0]
         && !edgeBus.hit[0]) |=> !pend_q[0];
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear write left pending set");

   property p_idle;
      idleGrant_q |-> $past(idleReq_q) && !$past(|active);
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle granted while wake pending");

   property p_no_wake;
      (active == 24'h0) |=> !wakeReq_q;
   endproperty
   a_no_wake: assert property (p_no_wake)
      else $error("wake request without enabled pending input");

   property p_wake;
      (|active) |=> wakeReq_q;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake request missing");

   property p_wko;
      1'b1 |=> (individualWakeOut[0] == $past(en_q[`WKU_IN20] ?
         pend_q[`WKU_IN20] : wakeInput[`WKU_IN20]));
   endproperty
   a_wko: assert property (p_wko)
      else $error("individual wake output wrong source");

   property p_grp;
      groupThreeInterrupt |-> $past(|(pend_q[23:16] & en_q[23:16]));
   endproperty
   a_grp: assert property (p_grp)
      else $error("group three line without cause");

   property p_comb;
      (indivAll[`WKU_IN24] && !en_q[`WKU_IN24]) |=> combinedWakeInterrupt;
   endproperty
   a_comb: assert property (p_comb)
      else $error("combined line missed output 24");

   property p_ready;
      (psel && penable && !pready_q) |=> pready_q ##1 !pready_q;
   endproperty
   a_ready: assert property (p_ready)
      else $error("bus answer timing wrong");

   property p_c_wake;
      !wakeReq_q ##1 wakeReq_q;
   endproperty
   c_wake: cover property (p_c_wake);

   property p_c_refuse;
      idleReq_q && (|active) ##1 stat_q[`WKU_EV_REFUSE];
   endproperty
   c_refuse: cover property (p_c_refuse);

   property p_c_irq;
      irq_q && groupThreeInterrupt;
   endproperty
   c_irq: cover property (p_c_irq);
endmodule
`default_nettype wire

// ---- dv/wku_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module wku_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wakeRequest,
   output logic [7:0] wakeCount
);
   logic wakeReq_q;
   logic [7:0] wakeCount_d;
   // power mode controller side: counts each new wake request
   always_comb begin
      wakeCount_d = wakeCount;
      if (wakeRequest && !wakeReq_q) begin
         wakeCount_d = wakeCount + 8'h01;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeReq_q <= 1'b0;
         wakeCount <= 8'h00;
      end else begin
         wakeReq_q <= wakeRequest;
         wakeCount <= wakeCount_d;
      end
   end
endmodule
`default_nettype wire

// ---- dv/wku_wake_unit_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wku_regs.svh"
module wku_wake_unit_tb;
   typedef struct {
      logic doWr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic err;
   } wku_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [23:0] wakeInput = 24'h0;
   logic pready, pslverr, wakeRequest, idleGrant, irq;
   logic groupOneInterrupt, groupThreeInterrupt, combinedWakeInterrupt;
   logic [31:0] prdata;
   logic [6:0] individualWakeOut;
   logic [7:0] wakeCount;
   int fails = 0;
   int cmp_count = 0;
   wku_row_t rows [15] = '{
      '{1'b0, `WKU_EDGE1_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b0, `WKU_PEND2_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b0, `WKU_PEND3_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `WKU_EDGE2_OFS, 32'h1a5, 32'ha5, 1'b0},
      '{1'b1, `WKU_EDGE3_OFS, 32'hff, 32'hff, 1'b0},
      '{1'b1, `WKU_EDGE3_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `WKU_EDGE2_OFS, 32'h40, 32'h40, 1'b0},
      '{1'b1, 8'h3c, 32'h55, 32'h0, 1'b1},
      '{1'b1, `WKU_EN3_OFS, 32'h5a, 32'h5a, 1'b0},
      '{1'b1, `WKU_EN3_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `WKU_MASK_OFS, 32'hff, 32'h3, 1'b0},
      '{1'b1, `WKU_MASK_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `WKU_CTL_OFS, 32'hff, 32'h1, 1'b0},
      '{1'b1, `WKU_CTL_OFS, 32'h0, 32'h0, 1'b0},
      '{1'b1, `WKU_PCL1_OFS, 32'hff, 32'h0, 1'b0}
   };
   wku_wake_unit i_wku_wake_unit (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .wakeInput(wakeInput), .wakeRequest(wakeRequest),
      .idleGrant(idleGrant), .individualWakeOut(individualWakeOut),
      .groupOneInterrupt(groupOneInterrupt),
      .groupThreeInterrupt(groupThreeInterrupt),
      .combinedWakeInterrupt(combinedWakeInterrupt), .irq(irq));
   wku_far_model i_wku_far_model (.clk(clk), .rst_n(rst_n),
      .wakeRequest(wakeRequest), .wakeCount(wakeCount));
   initial begin
      forever #20 clk = ~clk;
   end
   task end_of_test;
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         fails++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      check(name, rd, e);
   endtask
   task settle;
      repeat (4) @(posedge clk);
   endtask
   task pin(input int k, input logic v);
      @(posedge clk);
      wakeInput[k] <= v;
      settle();
   endtask
   initial begin
      logic [31:0] rd;
      logic er;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      foreach (rows[i]) begin
         if (rows[i].doWr) wr(rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0, rd, er);
         check("table data", rd, rows[i].exp);
         check("table err", 32'(er), 32'(rows[i].err));
      end
      // rising edge on an enabled input, then clear
      wr(`WKU_EN1_OFS, 32'h1);
      pin(0, 1'b1);
      rdc("pend1 rise", `WKU_PEND1_OFS, 32'h1);
      check("wakeReq", 32'(wakeRequest), 32'h1);
      check("grp1", 32'(groupOneInterrupt), 32'h1);
      check("comb", 32'(combinedWakeInterrupt), 32'h1);
      pin(0, 1'b0);
      rdc("pend1 held", `WKU_PEND1_OFS, 32'h1);
      wr(`WKU_PCL1_OFS, 32'hfe);
      rdc("clear zero", `WKU_PEND1_OFS, 32'h1);
      wr(`WKU_PCL1_OFS, 32'h1);
      settle();
      rdc("clear one", `WKU_PEND1_OFS, 32'h0);
      check("wakeReq off", 32'(wakeRequest), 32'h0);
      // power-on input on falling edge, not enabled
      wr(`WKU_EDGE1_OFS, 32'h80);
      pin(7, 1'b1);
      rdc("no rise", `WKU_PEND1_OFS, 32'h0);
      pin(7, 1'b0);
      rdc("fall", `WKU_PEND1_OFS, 32'h80);
      check("grp1 dis", 32'(groupOneInterrupt), 32'h0);
      wr(`WKU_PCL1_OFS, 32'h80);
      // disabled input latches but never wakes
      pin(16, 1'b1);
      rdc("pend3", `WKU_PEND3_OFS, 32'h1);
      check("no wake", 32'(wakeRequest), 32'h0);
      check("grp3 dis", 32'(groupThreeInterrupt), 32'h0);
      wr(`WKU_EN3_OFS, 32'h1);
      settle();
      check("grp3", 32'(groupThreeInterrupt), 32'h1);
      check("wake en", 32'(wakeRequest), 32'h1);
      wr(`WKU_PCL3_OFS, 32'h1);
      pin(16, 1'b0);
      check("grp3 clr", 32'(groupThreeInterrupt), 32'h0);
      // individual outputs raw while disabled, pending bit while enabled
      pin(15, 1'b1);
      check("out27 raw", 32'(individualWakeOut), 32'h40);
      pin(15, 1'b0);
      pin(14, 1'b1);
      check("in26 none", 32'(individualWakeOut), 32'h0);
      pin(12, 1'b1);
      check("out24 raw", 32'(individualWakeOut), 32'h10);
      check("comb24", 32'(combinedWakeInterrupt), 32'h1);
      pin(12, 1'b0);
      rdc("pend2", `WKU_PEND2_OFS, 32'h90);
      wr(`WKU_EN2_OFS, 32'h90);
      settle();
      check("out pend", 32'(individualWakeOut), 32'h50);
      wr(`WKU_PCL2_OFS, 32'hff);
      settle();
      check("out clr", 32'(individualWakeOut), 32'h0);
      wr(`WKU_EN2_OFS, 32'h0);
      pin(14, 1'b0);
      rdc("in26 fall", `WKU_PEND2_OFS, 32'h40);
      wr(`WKU_PCL2_OFS, 32'h40);
      // software set of a pending bit
      wr(`WKU_PEND1_OFS, 32'h1);
      wr(`WKU_PEND1_OFS, 32'h0);
      rdc("pend set", `WKU_PEND1_OFS, 32'h1);
      // idle refused while enabled and pending; interrupt path
      wr(`WKU_MASK_OFS, 32'h3);
      wr(`WKU_CTL_OFS, 32'h1);
      settle();
      check("idle refused", 32'(idleGrant), 32'h0);
      rdc("status", `WKU_STAT_OFS, 32'h3);
      check("irq", 32'(irq), 32'h1);
      wr(`WKU_MASK_OFS, 32'h0);
      settle();
      check("irq masked", 32'(irq), 32'h0);
      wr(`WKU_PCL1_OFS, 32'h1);
      settle();
      check("idle ok", 32'(idleGrant), 32'h1);
      wr(`WKU_STAT_OFS, 32'h3);
      wr(`WKU_MASK_OFS, 32'h3);
      settle();
      rdc("status clr", `WKU_STAT_OFS, 32'h0);
      check("irq clr", 32'(irq), 32'h0);
      check("wake count", 32'(wakeCount), 32'h4);
      // reset in mid-run clears pending and outputs
      wr(`WKU_PEND3_OFS, 32'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      check("rst grp3", 32'(groupThreeInterrupt), 32'h0);
      rst_n <= 1'b1;
      settle();
      rdc("rst pend3", `WKU_PEND3_OFS, 32'h0);
      rdc("rst edge1", `WKU_EDGE1_OFS, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
